// ### scsd_clock_ctrl.sv
`timescale 1ns/1ps

module scsd_clock_ctrl
  import scsd_pkg::*;
#(
  parameter int DIV_WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic timed_access_guard,
  input wire logic in_app_programming_enable,
  input wire logic fast_osc_ready_raw,
  input wire logic slow_osc_ready_raw,
  input wire logic off_chip_clock_ready_raw,
  output logic fast_internal_osc_enable,
  output logic off_chip_clock_enable,
  output logic shared_io_pin_gpio,
  output logic [1:0] active_clock_source,
  output logic sys_clock_tick,
  output logic sys_clock_level
);

  if (DIV_WIDTH < 1 || DIV_WIDTH > 8) begin : g_chk
    $error("DIV_WIDTH must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // Ready synchronisers
  // ----------------------------------------------------------------
  logic [2:0] rdy_meta_q;
  logic [2:0] rdy_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdy_meta_q <= 3'h0;
      rdy_q <= 3'h0;
    end else begin
      rdy_meta_q <= {off_chip_clock_ready_raw, slow_osc_ready_raw,
                     fast_osc_ready_raw};
      rdy_q <= rdy_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] sys_clock_divide_value_q;
  logic [7:0] sys_clock_divide_value_d;
  logic [1:0] off_chip_clock_enable_q;
  logic [1:0] off_chip_clock_enable_d;
  logic fast_internal_osc_enable_q;
  logic fast_internal_osc_enable_d;
  logic [1:0] clock_source_select_q;
  logic [1:0] clock_source_select_d;
  logic wr_div;
  logic wr_sw;
  logic wr_en;

  always_comb begin
    wr_div = sfr_wr && sfr_addr == SCSD_ADDR_DIVIDER;
    wr_sw = sfr_wr && timed_access_guard &&
            sfr_addr == SCSD_ADDR_SWITCH;
    wr_en = sfr_wr && timed_access_guard &&
            sfr_addr == SCSD_ADDR_ENABLE;
    sys_clock_divide_value_d = sys_clock_divide_value_q;
    off_chip_clock_enable_d = off_chip_clock_enable_q;
    fast_internal_osc_enable_d = fast_internal_osc_enable_q;
    clock_source_select_d = clock_source_select_q;
    if (wr_div) begin
      sys_clock_divide_value_d = sfr_wdata;
    end
    if (wr_sw) begin
      clock_source_select_d = sfr_wdata[SCSD_SW_SEL_LSB +: 2];
    end
    if (wr_en) begin
      off_chip_clock_enable_d = sfr_wdata[SCSD_EN_EXT_LSB +: 2];
      // Stored bit survives programming mode untouched
      fast_internal_osc_enable_d = sfr_wdata[SCSD_EN_FAST_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sys_clock_divide_value_q <= SCSD_DIVIDER_RST;
      off_chip_clock_enable_q <= SCSD_ENABLE_RST[SCSD_EN_EXT_LSB +: 2];
      fast_internal_osc_enable_q <= SCSD_ENABLE_RST[SCSD_EN_FAST_BIT];
      clock_source_select_q <= SCSD_SELECT_RST;
    end else begin
      sys_clock_divide_value_q <= sys_clock_divide_value_d;
      off_chip_clock_enable_q <= off_chip_clock_enable_d;
      fast_internal_osc_enable_q <= fast_internal_osc_enable_d;
      clock_source_select_q <= clock_source_select_d;
    end
  end

  // ----------------------------------------------------------------
  // Effective enables and stable flags
  // ----------------------------------------------------------------
  logic fast_en_eff;
  logic ext_en_eff;
  logic fast_internal_osc_stable;
  logic off_chip_clock_stable;
  logic slow_internal_osc_stable;

  always_comb begin
    fast_en_eff = fast_internal_osc_enable_q ||
                  in_app_programming_enable;
    ext_en_eff = off_chip_clock_enable_q == SCSD_EXT_ON;
    fast_internal_osc_stable = in_app_programming_enable ||
      (fast_internal_osc_enable_q && rdy_q[SCSD_RDY_FAST]);
    off_chip_clock_stable = ext_en_eff && rdy_q[SCSD_RDY_EXT];
    slow_internal_osc_stable = rdy_q[SCSD_RDY_SLOW];
  end

  function automatic logic src_ok(input logic [1:0] sel,
                                  input logic fast_st,
                                  input logic ext_st,
                                  input logic slow_st);
    logic ok;
    ok = 1'b0;
    case (sel)
      SCSD_SRC_FAST: ok = fast_st;
      SCSD_SRC_EXT: ok = ext_st;
      SCSD_SRC_SLOW: ok = slow_st;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // Source switch
  // ----------------------------------------------------------------
  scsd_sw_state_e sw_state_q;
  scsd_sw_state_e sw_state_d;
  logic [1:0] active_src_q;
  logic [1:0] active_src_d;
  logic [1:0] pend_src_q;
  logic [1:0] pend_src_d;
  logic switch_fault_flag_q;
  logic switch_fault_flag_d;
  logic [1:0] req_src;

  always_comb begin
    sw_state_d = sw_state_q;
    active_src_d = active_src_q;
    pend_src_d = pend_src_q;
    switch_fault_flag_d = switch_fault_flag_q;
    req_src = sfr_wdata[SCSD_SW_SEL_LSB +: 2];
    case (sw_state_q)
      SCSD_SW_IDLE: begin
      end
      SCSD_SW_WAIT: begin
        if (src_ok(pend_src_q, fast_internal_osc_stable,
                   off_chip_clock_stable, slow_internal_osc_stable)) begin
          active_src_d = pend_src_q;
          switch_fault_flag_d = 1'b0;
          sw_state_d = SCSD_SW_IDLE;
        end
      end
      default: sw_state_d = SCSD_SW_IDLE;
    endcase
    // A new request replaces any pending one
    if (wr_sw && req_src != SCSD_SRC_RSVD) begin
      if (src_ok(req_src, fast_internal_osc_stable,
                 off_chip_clock_stable, slow_internal_osc_stable)) begin
        active_src_d = req_src;
        switch_fault_flag_d = 1'b0;
        sw_state_d = SCSD_SW_IDLE;
      end else begin
        pend_src_d = req_src;
        switch_fault_flag_d = 1'b1;
        sw_state_d = SCSD_SW_WAIT;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sw_state_q <= SCSD_SW_IDLE;
      active_src_q <= SCSD_SRC_FAST;
      pend_src_q <= SCSD_SRC_FAST;
      switch_fault_flag_q <= 1'b0;
    end else begin
      sw_state_q <= sw_state_d;
      active_src_q <= active_src_d;
      pend_src_q <= pend_src_d;
      switch_fault_flag_q <= switch_fault_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  logic [DIV_WIDTH-1:0] div_cur_q;
  logic [DIV_WIDTH-1:0] div_cur_d;
  logic [DIV_WIDTH-1:0] div_cnt_q;
  logic [DIV_WIDTH-1:0] div_cnt_d;
  logic div_level_q;
  logic div_level_d;
  logic div_tick_q;
  logic div_tick_d;
  logic half_done;

  always_comb begin
    div_cur_d = div_cur_q;
    div_cnt_d = div_cnt_q;
    div_level_d = div_level_q;
    div_tick_d = 1'b0;
    half_done = div_cnt_q == div_cur_q - DIV_WIDTH'(1);
    if (div_cur_q == '0) begin
      div_tick_d = 1'b1;
      div_level_d = 1'b1;
      div_cnt_d = '0;
      div_cur_d = sys_clock_divide_value_q[DIV_WIDTH-1:0];
    end else if (half_done) begin
      div_cnt_d = '0;
      div_level_d = !div_level_q;
      div_tick_d = !div_level_q;
      if (div_level_q) begin
        // High half ends mid-period: point where the divisor reloads
        div_cur_d = sys_clock_divide_value_q[DIV_WIDTH-1:0];
      end
    end else begin
      div_cnt_d = div_cnt_q + DIV_WIDTH'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_cur_q <= SCSD_DIVIDER_RST[DIV_WIDTH-1:0];
      div_cnt_q <= '0;
      div_level_q <= 1'b0;
      div_tick_q <= 1'b0;
    end else begin
      div_cur_q <= div_cur_d;
      div_cnt_q <= div_cnt_d;
      div_level_q <= div_level_d;
      div_tick_q <= div_tick_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path and outputs
  // ----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic hit_q;
  logic hit_d;
  logic fast_en_q;
  logic ext_en_q;
  logic gpio_q;

  always_comb begin
    rdata_d = 8'h00;
    hit_d = 1'b0;
    if (sfr_rd) begin
      case (sfr_addr)
        SCSD_ADDR_DIVIDER: begin
          rdata_d = sys_clock_divide_value_q;
          hit_d = 1'b1;
        end
        SCSD_ADDR_SWITCH: begin
          rdata_d[SCSD_SW_FAST_ST_BIT] = fast_internal_osc_stable;
          rdata_d[SCSD_SW_SLOW_ST_BIT] = slow_internal_osc_stable;
          rdata_d[SCSD_SW_EXT_ST_BIT] = off_chip_clock_stable;
          // Last written select, not the live source
          rdata_d[SCSD_SW_SEL_LSB +: 2] = clock_source_select_q;
          hit_d = 1'b1;
        end
        SCSD_ADDR_ENABLE: begin
          rdata_d[SCSD_EN_EXT_LSB +: 2] = off_chip_clock_enable_q;
          rdata_d[SCSD_EN_FAST_BIT] = fast_en_eff;
          rdata_d[SCSD_EN_RSVD_BIT] = SCSD_ENABLE_RST[SCSD_EN_RSVD_BIT];
          rdata_d[SCSD_EN_FAULT_BIT] = switch_fault_flag_q;
          hit_d = 1'b1;
        end
        default: begin
          rdata_d = 8'h00;
          hit_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
      fast_en_q <= 1'b1;
      ext_en_q <= 1'b0;
      gpio_q <= 1'b1;
    end else begin
      rdata_q <= rdata_d;
      hit_q <= hit_d;
      fast_en_q <= fast_en_eff;
      ext_en_q <= ext_en_eff;
      gpio_q <= !ext_en_eff;
    end
  end

  assign sfr_rdata = rdata_q;
  assign sfr_hit = hit_q;
  assign fast_internal_osc_enable = fast_en_q;
  assign off_chip_clock_enable = ext_en_q;
  assign shared_io_pin_gpio = gpio_q;
  assign active_clock_source = active_src_q;
  assign sys_clock_tick = div_tick_q;
  assign sys_clock_level = div_level_q;

endmodule

// ### scsd_pkg.sv
package scsd_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SCSD_ADDR_DIVIDER = 8'h95;
  localparam logic [7:0] SCSD_ADDR_SWITCH = 8'h96;
  localparam logic [7:0] SCSD_ADDR_ENABLE = 8'h97;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SCSD_DIVIDER_RST = 8'h00;
  localparam logic [7:0] SCSD_ENABLE_RST = 8'h30;
  localparam logic [1:0] SCSD_SELECT_RST = 2'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCSD_SW_FAST_ST_BIT = 5;
  localparam int SCSD_SW_SLOW_ST_BIT = 4;
  localparam int SCSD_SW_EXT_ST_BIT = 3;
  localparam int SCSD_SW_SEL_LSB = 1;
  localparam int SCSD_EN_EXT_LSB = 6;
  localparam int SCSD_EN_FAST_BIT = 5;
  localparam int SCSD_EN_RSVD_BIT = 4;
  localparam int SCSD_EN_FAULT_BIT = 0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SCSD_SRC_FAST = 2'h0;
  localparam logic [1:0] SCSD_SRC_EXT = 2'h1;
  localparam logic [1:0] SCSD_SRC_SLOW = 2'h2;
  localparam logic [1:0] SCSD_SRC_RSVD = 2'h3;
  localparam logic [1:0] SCSD_EXT_ON = 2'h3;

  // Source ready bits in the synchronised vector
  localparam int SCSD_RDY_FAST = 0;
  localparam int SCSD_RDY_SLOW = 1;
  localparam int SCSD_RDY_EXT = 2;

  typedef enum logic [1:0] {
    SCSD_SW_IDLE = 2'h0,
    SCSD_SW_WAIT = 2'h1
  } scsd_sw_state_e;

endpackage

// ### scsd_osc_model.sv
`timescale 1ns/1ps
module scsd_osc_model (
  input wire logic sys_clk,
  input wire logic fast_internal_osc_enable,
  input wire logic off_chip_clock_enable,
  input wire logic [3:0] ext_delay,
  output logic fast_osc_ready_raw,
  output logic slow_osc_ready_raw,
  output logic off_chip_clock_ready_raw
);
  logic [3:0] fast_q = 4'h0;
  logic [3:0] ext_q = 4'h0;
  // Settling counters, cleared while an oscillator is off or unknown
  always @(posedge sys_clk) begin
    if (fast_internal_osc_enable) begin
      fast_q <= fast_q + 4'(fast_q != 4'hF);
    end else begin
      fast_q <= 4'h0;
    end
    if (off_chip_clock_enable) begin
      ext_q <= ext_q + 4'(ext_q != 4'hF);
    end else begin
      ext_q <= 4'h0;
    end
  end
  assign fast_osc_ready_raw = fast_q >= 4'h4;
  assign off_chip_clock_ready_raw = ext_q > ext_delay;
  assign slow_osc_ready_raw = 1'b1;
endmodule

// ### scsd_clock_ctrl_checker.sv
`timescale 1ns/1ps
module scsd_clock_ctrl_checker
  import scsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic timed_access_guard,
  input wire logic in_app_programming_enable,
  input wire logic fast_osc_ready_raw,
  input wire logic off_chip_clock_ready_raw,
  input wire logic fast_internal_osc_enable,
  input wire logic off_chip_clock_enable,
  input wire logic shared_io_pin_gpio,
  input wire logic [1:0] active_clock_source,
  input wire logic sys_clock_tick,
  input wire logic sys_clock_level
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  wire en_hit = sfr_wr && sfr_addr == SCSD_ADDR_ENABLE;
  wire wr_en = en_hit && timed_access_guard;
  wire wr_sw = sfr_wr && timed_access_guard && sfr_addr == SCSD_ADDR_SWITCH;
  wire ext_on = sfr_wdata[7:6] == SCSD_EXT_ON;
  wire fast_bit = sfr_wdata[SCSD_EN_FAST_BIT];
  wire sel_fast = sfr_wdata[2:1] == SCSD_SRC_FAST;
  chk_tick_level: assert property (sys_clock_tick |-> sys_clock_level)
    else $error("tick without high level");
  chk_rise_tick: assert property ($rose(sys_clock_level) |-> sys_clock_tick)
    else $error("level rise without tick");
  chk_pin_shared: assert property (off_chip_clock_enable != shared_io_pin_gpio)
    else $error("pin use disagrees with input enable");
  chk_ext_decode: assert property (
    wr_en |=> ##1 off_chip_clock_enable == $past(ext_on, 2))
    else $error("off-chip enable decode wrong");
  chk_guard_block: assert property (
    en_hit && !timed_access_guard |=> ##1 $stable(off_chip_clock_enable))
    else $error("unguarded write took effect");
  chk_fast_en: assert property (
    wr_en && !in_app_programming_enable |=> ##1
    ($past(in_app_programming_enable) ||
     fast_internal_osc_enable == $past(fast_bit, 2)))
    else $error("fast enable does not follow write");
  chk_prog_force: assert property (in_app_programming_enable |=> fast_internal_osc_enable)
    else $error("programming mode left fast osc off");
  chk_no_rsvd: assert property (active_clock_source != SCSD_SRC_RSVD)
    else $error("reserved source in use");
  chk_ext_ready: assert property (
    $changed(active_clock_source) && active_clock_source == SCSD_SRC_EXT
    |-> $past(off_chip_clock_ready_raw, 3))
    else $error("switched to unready off-chip clock");
  chk_fast_switch: assert property (
    wr_sw && sel_fast && fast_internal_osc_enable && fast_osc_ready_raw &&
    $past(fast_osc_ready_raw, 4) |=> active_clock_source == SCSD_SRC_FAST)
    else $error("switch to stable fast osc missed");
  cov_src_change: cover property ($changed(active_clock_source));
  cov_prog_mode: cover property (in_app_programming_enable);
  cov_div_rise: cover property ($rose(sys_clock_level));
endmodule

bind scsd_clock_ctrl scsd_clock_ctrl_checker scsd_clock_ctrl_checker_i (
  .sys_clk(sys_clk),
  .reset(reset),
  .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata),
  .timed_access_guard(timed_access_guard),
  .in_app_programming_enable(in_app_programming_enable),
  .fast_osc_ready_raw(fast_osc_ready_raw),
  .off_chip_clock_ready_raw(off_chip_clock_ready_raw),
  .fast_internal_osc_enable(fast_internal_osc_enable),
  .off_chip_clock_enable(off_chip_clock_enable),
  .shared_io_pin_gpio(shared_io_pin_gpio),
  .active_clock_source(active_clock_source),
  .sys_clock_tick(sys_clock_tick),
  .sys_clock_level(sys_clock_level)
);

// ### tb.sv
`timescale 1ns/1ps
module tb;
  import scsd_pkg::*;
  logic sys_clk = 0;
  logic reset = 1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 0;
  logic sfr_rd = 0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic timed_access_guard = 0;
  logic in_app_programming_enable = 0;
  logic fast_osc_ready_raw, slow_osc_ready_raw, off_chip_clock_ready_raw;
  logic fast_internal_osc_enable, off_chip_clock_enable, shared_io_pin_gpio;
  logic [1:0] active_clock_source;
  logic sys_clock_tick, sys_clock_level;
  logic [3:0] ext_delay = 4'h3;
  logic [7:0] n;
  int n_fail = 0;
  int check_count = 0;
  int seed = 32'hF084;
  scsd_clock_ctrl scsd_clock_ctrl_i (
    .sys_clk(sys_clk),
    .reset(reset),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .timed_access_guard(timed_access_guard),
    .in_app_programming_enable(in_app_programming_enable),
    .fast_osc_ready_raw(fast_osc_ready_raw),
    .slow_osc_ready_raw(slow_osc_ready_raw),
    .off_chip_clock_ready_raw(off_chip_clock_ready_raw),
    .fast_internal_osc_enable(fast_internal_osc_enable),
    .off_chip_clock_enable(off_chip_clock_enable),
    .shared_io_pin_gpio(shared_io_pin_gpio),
    .active_clock_source(active_clock_source),
    .sys_clock_tick(sys_clock_tick),
    .sys_clock_level(sys_clock_level)
  );
  scsd_osc_model scsd_osc_model_i (
    .sys_clk(sys_clk),
    .fast_internal_osc_enable(fast_internal_osc_enable),
    .off_chip_clock_enable(off_chip_clock_enable),
    .ext_delay(ext_delay),
    .fast_osc_ready_raw(fast_osc_ready_raw),
    .slow_osc_ready_raw(slow_osc_ready_raw),
    .off_chip_clock_ready_raw(off_chip_clock_ready_raw)
  );
  initial forever #5 sys_clk = ~sys_clk;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function logic [7:0] sw_exp(input logic f, s, e, input logic [1:0] c);
    return {2'h0, f, s, e, c, 1'b0};
  endfunction
  function logic [7:0] en_exp(input logic [1:0] x, input logic f, t);
    return {x, f, 4'h8, t};
  endfunction
  function logic [15:0] per_exp(input logic [7:0] d);
    return d == 8'h00 ? 16'h0001 : {7'h00, d, 1'b0};
  endfunction
  task wr(input logic [7:0] a, d, input logic g);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    timed_access_guard <= g;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    timed_access_guard <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1;
    chk(sfr_rdata, exp);
    chk(sfr_hit, a >= SCSD_ADDR_DIVIDER && a <= SCSD_ADDR_ENABLE);
  endtask
  task wait_src(input logic [1:0] s);
    for (int i = 0; i < 40 && active_clock_source !== s; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(active_clock_source, s);
  endtask
  task tick_wait(output int c);
    c = 0;
    do begin
      @(posedge sys_clk);
      #1;
      c++;
    end while (sys_clock_tick !== 1'b1);
  endtask
  task period(input logic [7:0] d);
    int c;
    repeat (3) tick_wait(c);
    chk(16'(c), per_exp(d));
  endtask
  task report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #60000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd(SCSD_ADDR_DIVIDER, SCSD_DIVIDER_RST);
    rd(SCSD_ADDR_ENABLE, SCSD_ENABLE_RST);
    rd(SCSD_ADDR_SWITCH, sw_exp(1'b1, 1'b1, 1'b0, SCSD_SELECT_RST));
    rd(8'h94, 8'h00);
    wr(SCSD_ADDR_ENABLE, 8'hE0, 1'b0);
    rd(SCSD_ADDR_ENABLE, en_exp(2'h0, 1'b1, 1'b0));
    ext_delay <= 4'h9;
    wr(SCSD_ADDR_SWITCH, 8'h02, 1'b1);
    rd(SCSD_ADDR_ENABLE, en_exp(2'h0, 1'b1, 1'b1));
    rd(SCSD_ADDR_SWITCH, sw_exp(1'b1, 1'b1, 1'b0, SCSD_SRC_EXT));
    wr(SCSD_ADDR_ENABLE, 8'hE0, 1'b1);
    rd(SCSD_ADDR_ENABLE, en_exp(SCSD_EXT_ON, 1'b1, 1'b1));
    chk(shared_io_pin_gpio, 1'b0);
    chk(active_clock_source, SCSD_SRC_FAST);
    wait_src(SCSD_SRC_EXT);
    rd(SCSD_ADDR_ENABLE, en_exp(SCSD_EXT_ON, 1'b1, 1'b0));
    rd(SCSD_ADDR_SWITCH, sw_exp(1'b1, 1'b1, 1'b1, SCSD_SRC_EXT));
    wr(SCSD_ADDR_SWITCH, 8'h00, 1'b1);
    wait_src(SCSD_SRC_FAST);
    for (int x = 0; x < 3; x++) begin
      wr(SCSD_ADDR_ENABLE, {2'(x), 6'h20}, 1'b1);
      @(posedge sys_clk);
      #1;
      chk(off_chip_clock_enable, 1'b0);
      chk(shared_io_pin_gpio, 1'b1);
    end
    wr(SCSD_ADDR_SWITCH, 8'h04, 1'b1);
    wait_src(SCSD_SRC_SLOW);
    wr(SCSD_ADDR_ENABLE, 8'h00, 1'b1);
    @(posedge sys_clk);
    #1;
    chk(fast_internal_osc_enable, 1'b0);
    wr(SCSD_ADDR_SWITCH, 8'h00, 1'b1);
    rd(SCSD_ADDR_SWITCH, sw_exp(1'b0, 1'b1, 1'b0, SCSD_SRC_FAST));
    rd(SCSD_ADDR_ENABLE, en_exp(2'h0, 1'b0, 1'b1));
    chk(active_clock_source, SCSD_SRC_SLOW);
    @(posedge sys_clk);
    in_app_programming_enable <= 1'b1;
    wait_src(SCSD_SRC_FAST);
    rd(SCSD_ADDR_ENABLE, en_exp(2'h0, 1'b1, 1'b0));
    rd(SCSD_ADDR_SWITCH, sw_exp(1'b1, 1'b1, 1'b0, SCSD_SRC_FAST));
    @(posedge sys_clk);
    in_app_programming_enable <= 1'b0;
    rd(SCSD_ADDR_ENABLE, en_exp(2'h0, 1'b0, 1'b0));
    wr(SCSD_ADDR_ENABLE, 8'h20, 1'b1);
    wr(SCSD_ADDR_SWITCH, 8'h06, 1'b1);
    chk(active_clock_source, SCSD_SRC_FAST);
    rd(SCSD_ADDR_ENABLE, en_exp(2'h0, 1'b1, 1'b0));
    for (int k = 0; k < 8; k++) begin
      n = k < 2 ? 8'(k) : (k == 2 ? 8'hFF : 8'($random(seed) & 7));
      wr(SCSD_ADDR_DIVIDER, n, 1'b0);
      rd(SCSD_ADDR_DIVIDER, n);
      period(n);
    end
    report_and_stop();
  end
endmodule
